// ### logic/clk_ctrl_pkg.sv
/*
 * Shared constants and types of the clock prescale and switch control block:
 * register offsets, field positions, reset codes, command codes, carriers.
 * Assumes a 32-bit APB bus with 12-bit byte addresses and 8-bit registers.
 */
package clk_ctrl_pkg;

	// register byte addresses, one aligned word each
	localparam logic [11:0] DIV_CTRL_OFFS   = 12'h000;
	localparam logic [11:0] CMD_STAT_OFFS   = 12'h004;
	localparam logic [11:0] SRC_CHOICE_OFFS = 12'h008;

	// field positions
	localparam int UNLOCK_BIT  = 7;
	localparam int READY_BIT   = 4;
	localparam int CLKOUT_BIT  = 6;
	localparam int STARTUP_LSB = 4;

	// protected write procedure
	localparam logic [7:0] UNLOCK_VALUE  = 8'h80;
	localparam int         UNLOCK_CYCLES = 4;

	// divide-select codes
	localparam logic [3:0] DIVSEL_RESET_PLAIN = 4'h0;
	localparam logic [3:0] DIVSEL_RESET_DIV8  = 4'h3;
	localparam logic [3:0] DIVSEL_MAX         = 4'h8;
	localparam int         DIV_COUNT_W        = 8;

	// clock switch commands
	typedef enum logic [3:0] {
		CMD_NONE    = 4'h0,
		CMD_DISABLE = 4'h1,
		CMD_ENABLE  = 4'h2,
		CMD_AVAIL   = 4'h3,
		CMD_SWITCH  = 4'h4,
		CMD_RECOVER = 4'h5,
		CMD_WDT_ARL = 4'h6,
		CMD_CLKOUT  = 4'h7
	} cmd_t;

	// request handed to the clock switch module
	typedef struct packed {
		logic       valid;
		cmd_t       code;
		logic [3:0] source;
		logic [1:0] startup;
		logic       clock_out;
	} switch_req_t;

	// fuse levels, read once after reset
	typedef struct packed {
		logic       div_by_eight_fuse;
		logic       clock_output_fuse;
		logic [1:0] startup_fuse;
		logic [3:0] source_select_fuse;
	} fuses_t;

endpackage

// ### logic/unlock_window.sv
/*
 * Timed unlock window for one protected register.
 * Assumes wr is a one-cycle write strobe with wdata valid alongside it.
 */
module unlock_window
	import clk_ctrl_pkg::*;
#(
	parameter int WINDOW = UNLOCK_CYCLES
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// write from the bus
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	// window state
	output logic            unlocked,
	output logic            accept
);

	typedef enum logic {LOCKED = 1'b0, OPEN = 1'b1} win_state_t;

	win_state_t      state_reg;
	logic [2:0]      age_reg;
	logic            unlock_wr;

	assign unlock_wr = wr && (wdata == UNLOCK_VALUE);
	// a protected write needs the window open and the unlock bit low
	assign accept = wr && (state_reg == OPEN) && !wdata[UNLOCK_BIT];
	assign unlocked = (state_reg == OPEN);

	// window opens on the lone unlock bit, closes on age or accepted write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= LOCKED;
			age_reg   <= 3'h0;
		end else if (ce) begin
			unique case (state_reg)
				LOCKED: begin
					if (unlock_wr) begin
						state_reg <= OPEN;
						age_reg   <= 3'h0;
					end
				end
				OPEN: begin
					// rewrite of the unlock value neither extends nor closes
					if (accept || age_reg == 3'(WINDOW - 1)) begin
						state_reg <= LOCKED;
					end
					age_reg <= age_reg + 3'h1;
				end
			endcase
		end
	end

endmodule

// ### logic/pow2_divider.sv
/*
 * Power-of-two divider producing a one-cycle clock enable for the system.
 * Assumes sel_req may change at any time; it is taken only at a period end.
 */
module pow2_divider
	import clk_ctrl_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	// requested divide code
	input  wire logic [3:0] sel_req,
	// divided clock enable
	output logic            tick
);

	logic [DIV_COUNT_W-1:0] count_reg;
	logic [3:0]             active_reg;
	logic [DIV_COUNT_W-1:0] limit;

	// reserved codes divide like the largest legal one
	always_comb begin
		if (active_reg > DIVSEL_MAX) begin
			limit = '1;
		end else begin
			limit = DIV_COUNT_W'((9'h1 << active_reg) - 9'h1);
		end
	end

	// new code only at a period end, so no short period is ever emitted
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg  <= '0;
			active_reg <= DIVSEL_RESET_PLAIN;
			tick       <= 1'b0;
		end else if (ce) begin
			tick <= (count_reg >= limit);
			if (count_reg >= limit) begin
				count_reg  <= '0;
				active_reg <= sel_req;
			end else begin
				count_reg <= count_reg + DIV_COUNT_W'(1);
			end
		end
	end

endmodule

// ### logic/clock_prescale_switch_ctrl.sv
/*
 * Clock prescale and switch control: APB registers for the system clock
 * prescaler, the protected command register of the clock switch module and
 * the clock source choice register.
 * Assumes a zero-wait APB master on pclk, fuse levels stable from reset on,
 * and an availability checker that pulses avail_confirm for a good source.
 */
// Our own choices: the register addresses and the APB interface to the registers.

module clock_prescale_switch_ctrl
	import clk_ctrl_pkg::*;
(
	// clock, reset, enable
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// fuses
	input  wire fuses_t      fuses,
	// clock switch module
	input  wire logic        avail_confirm,
	input  wire logic [3:0]  current_source,
	output switch_req_t      switch_req,
	// divided system clock enable
	output logic             sysclk_en
);

	logic              setup_phase;
	logic              wr_fire;
	logic              hit_div;
	logic              hit_cmd;
	logic              hit_sel;
	logic              hit_any;
	logic [7:0]        wdata8;
	logic [7:0]        rd_mux;

	logic              fuse_loaded_reg;
	logic [3:0]        divide_select_reg;
	logic [3:0]        switch_command_code_reg;
	logic              source_ready_flag_reg;
	logic              clock_output_on_reg;
	logic [1:0]        startup_time_code_reg;
	logic [3:0]        source_select_code_reg;

	logic              divider_change_unlock;
	logic              div_accept;
	logic              command_change_unlock;
	logic              cmd_accept;
	cmd_t              cmd_issued;

	// bus decode
	assign setup_phase = psel && !penable;
	assign wr_fire     = psel && penable && pready && pwrite;
	assign hit_div     = (paddr == DIV_CTRL_OFFS);
	assign hit_cmd     = (paddr == CMD_STAT_OFFS);
	assign hit_sel     = (paddr == SRC_CHOICE_OFFS);
	assign hit_any     = hit_div || hit_cmd || hit_sel;
	assign wdata8      = pwdata[7:0];

	// 1xxx codes decode as no command
	assign cmd_issued = wdata8[3] ? CMD_NONE : cmd_t'(wdata8[3:0]);

	// protected divider window
	// opens only on the lone unlock bit
	// closes on age or accepted divide write
	unlock_window #(
		.WINDOW   (UNLOCK_CYCLES)
	) u_div_unlock (
		.clk      (pclk),
		.rst_n    (presetn),
		.ce       (clk_en),
		.wr       (wr_fire && hit_div),
		.wdata    (wdata8),
		.unlocked (divider_change_unlock),
		.accept   (div_accept)
	);

	// protected command window
	// lone-bit unlock, four-cycle life
	unlock_window #(
		.WINDOW   (UNLOCK_CYCLES)
	) u_cmd_unlock (
		.clk      (pclk),
		.rst_n    (presetn),
		.ce       (clk_en),
		.wr       (wr_fire && hit_cmd),
		.wdata    (wdata8),
		.unlocked (command_change_unlock),
		.accept   (cmd_accept)
	);

	// read mux; reserved bits are wired to zero
	always_comb begin
		rd_mux = 8'h00;
		if (hit_div) begin
			rd_mux = {divider_change_unlock, 3'h0, divide_select_reg};
		end else if (hit_cmd) begin
			rd_mux = {command_change_unlock, 2'h0, source_ready_flag_reg,
				switch_command_code_reg};
		end else if (hit_sel) begin
			rd_mux = {1'b0, clock_output_on_reg, startup_time_code_reg,
				source_select_code_reg};
		end
	end

	// apb answer: one access cycle, data sampled in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else if (clk_en) begin
			pready <= setup_phase;
		end
	end

	// read data register, upper bits always zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			if (setup_phase && !pwrite) begin
				prdata <= {24'h00_0000, rd_mux};
			end else if (setup_phase) begin
				prdata <= 32'h0000_0000;
			end
		end
	end

	// unmapped addresses answer with an error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else if (clk_en) begin
			pslverr <= setup_phase && !hit_any;
		end
	end

	// fuse capture marker; fuses are read after reset, not under it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fuse_loaded_reg <= 1'b0;
		end else if (clk_en) begin
			fuse_loaded_reg <= 1'b1;
		end
	end

	// divide select
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divide_select_reg <= DIVSEL_RESET_PLAIN;
		end else if (clk_en) begin
			if (!fuse_loaded_reg) begin
				// fuse picks plain or divide by eight
				divide_select_reg <= fuses.div_by_eight_fuse ? DIVSEL_RESET_DIV8 : DIVSEL_RESET_PLAIN;
			end else if (div_accept) begin
				// any code accepted, reserved ones too
				// bits 6:4 of the write are dropped
				divide_select_reg <= wdata8[3:0];
			end
		end
	end

	// code switched only at a period end
	pow2_divider u_divider (
		.clk     (pclk),
		.rst_n   (presetn),
		.ce      (clk_en),
		.sel_req (divide_select_reg),
		.tick    (sysclk_en)
	);

	// last command written, kept for read-back
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_command_code_reg <= 4'h0;
		end else if (clk_en) begin
			// a locked command write is ignored
			if (cmd_accept) begin
				switch_command_code_reg <= wdata8[3:0];
			end
		end
	end

	// one-cycle request to the clock switch module
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			switch_req <= '0;
		end else if (clk_en) begin
			switch_req.valid <= 1'b0;
			// only codes 1..7 reach the switch
			if (cmd_accept && cmd_issued != CMD_NONE) begin
				switch_req.valid     <= 1'b1;
				switch_req.code      <= cmd_issued;
				// source field is the command target
				switch_req.source    <= source_select_code_reg;
				// start-up code travels with the command
				switch_req.startup   <= startup_time_code_reg;
				// clock-out bit for the clock-out command
				switch_req.clock_out <= clock_output_on_reg;
			end
		end
	end

	// ready flag; a confirm in the clearing cycle still sets it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_ready_flag_reg <= 1'b0;
		end else if (clk_en) begin
			if (avail_confirm) begin
				source_ready_flag_reg <= 1'b1;
			end else if (cmd_accept && (cmd_issued == CMD_AVAIL || cmd_issued == CMD_ENABLE)) begin
				source_ready_flag_reg <= 1'b0;
			end
		end
	end

	// clock-out bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_output_on_reg <= 1'b0;
		end else if (clk_en) begin
			if (!fuse_loaded_reg) begin
				clock_output_on_reg <= ~fuses.clock_output_fuse;
			end else if (wr_fire && hit_sel) begin
				clock_output_on_reg <= wdata8[CLKOUT_BIT];
			end
		end
	end

	// start-up code; recover leaves it alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			startup_time_code_reg <= 2'h0;
		end else if (clk_en) begin
			if (!fuse_loaded_reg) begin
				startup_time_code_reg <= fuses.startup_fuse;
			end else if (wr_fire && hit_sel) begin
				startup_time_code_reg <= wdata8[STARTUP_LSB +: 2];
			end
		end
	end

	// source code
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			source_select_code_reg <= 4'h0;
		end else if (clk_en) begin
			if (!fuse_loaded_reg) begin
				source_select_code_reg <= fuses.source_select_fuse;
			end else if (cmd_accept && cmd_issued == CMD_RECOVER) begin
				// recover reads back the live source
				source_select_code_reg <= current_source;
			end else if (wr_fire && hit_sel) begin
				// bit 7 of the write is dropped
				source_select_code_reg <= wdata8[3:0];
			end
		end
	end

endmodule

// ### bench/clk_ctrl_asserts.sv
/* Port checker of the clock prescale and switch control block.
 Assumes a bind onto the top module and one pclk domain. */
module clk_ctrl_asserts
	import clk_ctrl_pkg::*;
(
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        clk_en,
	// apb side
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// switch request
	input wire switch_req_t switch_req
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic mapped;
	logic cmd_wr;
	logic rd_ok;

	// decoded address and an accepted command write of codes 1..7
	assign mapped = paddr == DIV_CTRL_OFFS || paddr == CMD_STAT_OFFS || paddr == SRC_CHOICE_OFFS;
	assign cmd_wr = psel && penable && pready && pwrite && paddr == CMD_STAT_OFFS
		&& !pwdata[7] && !pwdata[3] && pwdata[2:0] != 3'h0;
	assign rd_ok = pready && !pwrite;

	ready_after_setup_a: assert property (psel && !penable && clk_en |=> pready)
		else $error("no answer one cycle after setup");
	ready_pulse_a: assert property (pready && clk_en |=> !pready)
		else $error("pready held past one cycle");
	unmapped_err_a: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr does not match address map");
	upper_zero_a: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	div_resv_a: assert property (rd_ok && paddr == DIV_CTRL_OFFS |-> prdata[6:4] == 3'h0)
		else $error("divider reserved bits read nonzero");
	cmd_resv_a: assert property (rd_ok && paddr == CMD_STAT_OFFS |-> prdata[6:5] == 2'h0)
		else $error("command reserved bits read nonzero");
	src_resv_a: assert property (rd_ok && paddr == SRC_CHOICE_OFFS |-> !prdata[7])
		else $error("source choice bit 7 read nonzero");
	req_cause_a: assert property ($rose(switch_req.valid) |-> $past(cmd_wr) || $past(cmd_wr, 2))
		else $error("switch request without command write");
	req_pulse_a: assert property (switch_req.valid && clk_en |=> !switch_req.valid)
		else $error("switch request longer than one cycle");
	req_code_a: assert property (switch_req.valid |-> !switch_req.code[3] && switch_req.code != CMD_NONE)
		else $error("switch request with a no-command code");
endmodule

bind clock_prescale_switch_ctrl clk_ctrl_asserts chk_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .switch_req);

// ### bench/clock_prescale_switch_ctrl_test.sv
/* Self-checking bench of the clock prescale and switch control block.
 Assumes the package, the design and its checker are compiled first. */
module clock_prescale_switch_ctrl_test
	import clk_ctrl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic        pready, pslverr, sysclk_en, avail_confirm = 0, ev, rdy;
	logic [3:0]  current_source = 4'ha, src;
	logic [7:0]  rv;
	fuses_t      fuses = 8'ha5;
	switch_req_t switch_req, got;
	int          mismatches = 0, check_count = 0, n;

	clock_prescale_switch_ctrl dut_u (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .fuses, .avail_confirm, .current_source, .switch_req, .sysclk_en);

	always #50 pclk = ~pclk;

	task automatic check(input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; waits as long as pready takes
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rv = prdata[7:0];
		ev = pslverr;
		psel <= 0;
		penable <= 0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [7:0] e);
		xfer(0, a, 8'h00);
		check(rv, e);
	endtask

	// unbroken unlock then data; gap 0/1/2 lands at E+3/E+4/E+5
	task automatic prot(input logic [11:0] a, input logic [7:0] d, input int gap);
		xfer(1, a, UNLOCK_VALUE);
		repeat (gap) @(posedge pclk);
		xfer(1, a, d);
	endtask

	// edges from 2nd to 3rd tick, past any changing period
	task automatic period();
		int p;
		p = 0;
		n = 0;
		while (p < 3 && n < 2000) begin
			@(posedge pclk);
			n++;
			if (sysclk_en === 1'b1) begin
				p++;
				if (p < 3) n = 0;
			end
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	initial begin
		#3000000;
		mismatches++;
		give_verdict();
	end

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		rdc(DIV_CTRL_OFFS, 8'h03);
		rdc(SRC_CHOICE_OFFS, 8'h65);
		xfer(1, DIV_CTRL_OFFS, 8'h81);
		xfer(1, DIV_CTRL_OFFS, 8'h05);
		rdc(DIV_CTRL_OFFS, 8'h03);
		xfer(1, DIV_CTRL_OFFS, UNLOCK_VALUE);
		clk_en <= 0;
		repeat (8) @(posedge pclk);
		clk_en <= 1;
		rdc(DIV_CTRL_OFFS, 8'h83);
		rdc(DIV_CTRL_OFFS, 8'h03);
		prot(DIV_CTRL_OFFS, 8'h01, 2);
		rdc(DIV_CTRL_OFFS, 8'h03);
		prot(DIV_CTRL_OFFS, 8'h01, 1);
		rdc(DIV_CTRL_OFFS, 8'h01);
		xfer(1, DIV_CTRL_OFFS, UNLOCK_VALUE);
		prot(DIV_CTRL_OFFS, 8'h02, 0);
		rdc(DIV_CTRL_OFFS, 8'h01);
		for (int c = 0; c <= 9; c++) begin
			prot(DIV_CTRL_OFFS, c[7:0], 0);
			rdc(DIV_CTRL_OFFS, c[7:0]);
			period();
			check(n, c > 8 ? 256 : 1 << c);
		end
		presetn <= 0;
		fuses <= 8'h53;
		repeat (8) @(posedge pclk);
		presetn <= 1;
		repeat (2) @(posedge pclk);
		rdc(DIV_CTRL_OFFS, 8'h00);
		rdc(SRC_CHOICE_OFFS, 8'h13);
		xfer(1, SRC_CHOICE_OFFS, 8'hd3);
		rdc(SRC_CHOICE_OFFS, 8'h53);
		src = 4'h3;
		for (int c = 1; c <= 8; c++) begin
			avail_confirm <= 1;
			@(posedge pclk);
			avail_confirm <= 0;
			rdy = 1;
			prot(CMD_STAT_OFFS, c[7:0], 0);
			got = '0;
			repeat (3) begin
				@(posedge pclk);
				if (switch_req.valid === 1'b1) got = switch_req;
			end
			check(got.valid, c < 8);
			check(got.code, c < 8 ? c[3:0] : 4'h0);
			if (c != 5 && c < 8) check({got.source, got.startup, got.clock_out}, {src, 3'b011});
			if (c == 2 || c == 3) rdy = 0;
			rdc(CMD_STAT_OFFS, {3'b000, rdy, c[3:0]});
			if (c == 5) begin
				src = current_source;
				rdc(SRC_CHOICE_OFFS, 8'h5a);
			end
		end
		prot(CMD_STAT_OFFS, 8'h02, 2);
		rdc(CMD_STAT_OFFS, {3'b000, rdy, 4'h8});
		xfer(1, 12'h00c, 8'hff);
		xfer(0, 12'h00c, 8'h00);
		check({ev, rv}, 9'h100);
		give_verdict();
	end
endmodule
